// ==== common/hrp_mem_if.sv ====
`timescale 1ns/1ps
`include "hrp_regs.svh"
interface hrp_mem_if;
  import hrp_pkg::*;

  logic                  wr_en;
  logic [`HRP_LANES-1:0] wr_be;
  hrp_cw_addr_t          wr_addr;
  hrp_word_t             wr_data;
  hrp_cw_addr_t          rd_addr;
  hrp_word_t             rd_data;

  modport mem  (input wr_en, input wr_be, input wr_addr, input wr_data,
                input rd_addr, output rd_data);
  modport user (output wr_en, output wr_be, output wr_addr, output wr_data,
                output rd_addr, input rd_data);
endinterface

// ==== common/hrp_pkg.sv ====
package hrp_pkg;
  `include "hrp_regs.svh"

  typedef logic [31:0]            hrp_word_t;
  typedef logic [`HRP_CW_AW-1:0]  hrp_cw_addr_t;

  // Read path sequencing
  typedef enum logic [1:0] {
    HRP_RD_IDLE,
    HRP_RD_MEM,
    HRP_RD_DONE
  } hrp_rd_state_e;
endpackage

// ==== common/hrp_regs.svh ====
`ifndef HRP_REGS_SVH
`define HRP_REGS_SVH

// ----------------------------------------------------------------------
// Register word indices (word addressing; byte address is index * 4)
// ----------------------------------------------------------------------
`define HRP_OFS_INT_STATUS   16'h0000
`define HRP_OFS_INT_ENABLE   16'h0001
`define HRP_OFS_L1_CFG       16'h0002
`define HRP_OFS_CTRL_INDEX   16'h0003
`define HRP_OFS_RX_CTRL      16'h0004
`define HRP_OFS_TX_CTRL      16'h0005
`define HRP_OFS_CORE_STATUS  16'h0006

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define HRP_BYTE_SHIFT       2
`define HRP_IDX_RX_X         7:0
`define HRP_IDX_RX_SEQ       11:8
`define HRP_IDX_TX_X         23:16
`define HRP_IDX_TX_SEQ       27:24
`define HRP_L1_TX_CW_EN      0

// ----------------------------------------------------------------------
// Sizes and reset values
// ----------------------------------------------------------------------
`define HRP_EVENTS           8
`define HRP_LANES            4
`define HRP_CW_SECTIONS      4'hc
`define HRP_CW_AW            12
`define HRP_CW_DEPTH         4096
`define HRP_ZERO             32'h0000_0000
`define HRP_RST_INT_ENABLE   32'h0000_0000
`define HRP_RST_L1_CFG       32'h0000_0000
`define HRP_RST_CTRL_INDEX   32'h0000_0000

`endif

// ==== hdl/hrp_cw_mem.sv ====
`timescale 1ns/1ps
`include "hrp_regs.svh"
module hrp_cw_mem
  import hrp_pkg::*;
(
  input wire logic  ref_clk,
  hrp_mem_if.mem    port
);

  wire logic [`HRP_LANES-1:0][7:0] rd_word;

  // ----------------------------------------------------------------------
  // Byte lanes, one bank each
  // ----------------------------------------------------------------------
  // A bank per lane keeps a single writer per array; no reset, so block RAM
  for (genvar lane = 0; lane < `HRP_LANES; lane++) begin : g_lane
    logic [7:0] bank [0:`HRP_CW_DEPTH-1];
    logic [7:0] rd_byte;

    // Lane written only when its enable is set
    always_ff @(posedge ref_clk) begin
      if (port.wr_en && port.wr_be[lane]) begin
        bank[port.wr_addr] <= port.wr_data[8*lane +: 8];
      end
    end

    // Registered read of this lane
    always_ff @(posedge ref_clk) begin
      rd_byte <= bank[port.rd_addr];
    end

    assign rd_word[lane] = rd_byte;
  end

  // Lanes gathered back into one word
  assign port.rd_data = rd_word;

endmodule // hrp_cw_mem

// ==== hdl/hrp_top.sv ====
// Contract
// - Everything sampled and driven on one clock
// - Reset clears port logic and all registers
// - 32-bit registers, word address selects one
// - Byte-address option uses address as bytes
// - Four byte enables, honoured per lane
// - One register per access, no bursts
// - Wait-request high until done; host holds
// - Any enabled event raises the interrupt
// - Only core registers reachable, nothing else
// - Option exposes all 256 control words
// - Index, receive, transmit, layer-1 steer words
// - Index is subchannel plus 64 times position
// - Index fields name word being accessed
// - Wide words read in 32-bit sections
`timescale 1ns/1ps
`include "hrp_regs.svh"
module hrp_top
  import hrp_pkg::*;
#(
  parameter bit BYTE_ADDRESSING = 1'b0,
  parameter bit CW_ACCESS_EN    = 1'b1
) (
  input  wire logic                  ref_clk,
  input  wire logic                  reset_n,
  input  wire logic [15:0]           host_address,
  input  wire logic [`HRP_LANES-1:0] host_byteenable,
  input  wire logic                  host_read,
  input  wire logic                  host_write,
  input  wire logic [31:0]           host_writedata,
  output logic      [31:0]           host_readdata,
  output logic                       host_waitrequest,
  output logic                       host_irq,
  input  wire logic [`HRP_EVENTS-1:0] core_event,
  input  wire logic [31:0]           core_status,
  output logic      [31:0]           layer1_config,
  input  wire logic                  rx_cw_wr_en,
  input  wire logic [7:0]            rx_cw_index,
  input  wire logic [3:0]            rx_cw_seq,
  input  wire logic [31:0]           rx_cw_data,
  input  wire logic [7:0]            tx_cw_index,
  input  wire logic [3:0]            tx_cw_seq,
  output logic      [31:0]           tx_cw_data
);

  // ----------------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------------
  logic                   rst_meta;
  logic                   rst_n;
  logic [15:0]            reg_index;
  logic                   wr_req;
  logic                   hit_status;
  logic                   hit_enable;
  logic                   hit_l1;
  logic                   hit_index;
  logic                   hit_rx;
  logic                   hit_tx;
  hrp_word_t              lane_mask;
  hrp_word_t              int_status;
  hrp_word_t              int_enable;
  hrp_word_t              layer1_configuration_reg;
  hrp_word_t              ctrl_index;
  hrp_word_t              next_int_status;
  hrp_word_t              read_mux;
  hrp_rd_state_e          rd_state;
  logic                   rx_seq_ok;
  logic                   tx_seq_ok;
  logic                   link_seq_ok;
  hrp_mem_if              rx_mem ();
  hrp_mem_if              tx_mem ();

  // Byte enables expanded to a bit mask
  function automatic hrp_word_t lanes_to_mask(logic [`HRP_LANES-1:0] be);
    hrp_word_t m;
    m = `HRP_ZERO;
    for (int i = 0; i < `HRP_LANES; i++) begin
      m[8*i +: 8] = {8{be[i]}};
    end
    return m;
  endfunction

  // ----------------------------------------------------------------------
  // Reset release
  // ----------------------------------------------------------------------
  // Assert at once, release through two flops so no flop sees a runt edge
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      rst_meta <= 1'b0;
      rst_n    <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_n    <= rst_meta;
    end
  end

  // ----------------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------------
  // Word index; in byte mode the two low bits are dropped and lanes come from the byte enables
  assign reg_index = BYTE_ADDRESSING ?
                     {{`HRP_BYTE_SHIFT{1'b0}}, host_address[15:`HRP_BYTE_SHIFT]} :
                     host_address;
  assign lane_mask  = lanes_to_mask(host_byteenable);
  // A simultaneous read and write is treated as a read
  assign wr_req     = host_write && !host_read;
  // Only the core's own registers decode; all else falls to zero
  assign hit_status = (reg_index == `HRP_OFS_INT_STATUS);
  assign hit_enable = (reg_index == `HRP_OFS_INT_ENABLE);
  assign hit_l1     = (reg_index == `HRP_OFS_L1_CFG);
  assign hit_index  = (reg_index == `HRP_OFS_CTRL_INDEX);
  assign hit_rx     = CW_ACCESS_EN && (reg_index == `HRP_OFS_RX_CTRL);
  assign hit_tx     = CW_ACCESS_EN && (reg_index == `HRP_OFS_TX_CTRL);

  // Sections beyond the widest line rate do not exist
  assign rx_seq_ok   = (ctrl_index[`HRP_IDX_RX_SEQ] < `HRP_CW_SECTIONS);
  assign tx_seq_ok   = (ctrl_index[`HRP_IDX_TX_SEQ] < `HRP_CW_SECTIONS);
  assign link_seq_ok = (rx_cw_seq < `HRP_CW_SECTIONS);

  // ----------------------------------------------------------------------
  // Configuration registers
  // ----------------------------------------------------------------------
  // Interrupt enable mask, per-lane writes
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      int_enable <= `HRP_RST_INT_ENABLE;
    end else if (wr_req && hit_enable) begin
      int_enable <= (int_enable & ~lane_mask) | (host_writedata & lane_mask);
    end
  end

  // Layer-1 configuration; its enable bit gates transmit word writes
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      layer1_configuration_reg <= `HRP_RST_L1_CFG;
    end else if (wr_req && hit_l1) begin
      layer1_configuration_reg <= (layer1_configuration_reg & ~lane_mask) |
                                  (host_writedata & lane_mask);
    end
  end

  // Control-word index: receive and transmit word and section
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_index <= `HRP_RST_CTRL_INDEX;
    end else if (wr_req && hit_index) begin
      ctrl_index <= (ctrl_index & ~lane_mask) | (host_writedata & lane_mask);
    end
  end

  assign layer1_config = layer1_configuration_reg;

  // ----------------------------------------------------------------------
  // Interrupt status
  // ----------------------------------------------------------------------
  // Write one to clear; an event in the clearing cycle wins over the clear
  always_comb begin
    next_int_status = int_status;
    if (wr_req && hit_status) begin
      next_int_status = int_status & ~(host_writedata & lane_mask);
    end
    next_int_status[`HRP_EVENTS-1:0] = next_int_status[`HRP_EVENTS-1:0] | core_event;
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      int_status <= `HRP_ZERO;
    end else begin
      int_status <= next_int_status;
    end
  end

  // Single line; software reads the status word to find the cause
  assign host_irq = |(int_status & int_enable);

  // ----------------------------------------------------------------------
  // Control-word tables
  // ----------------------------------------------------------------------
  // Address is section above word index: X = subchannel + 64 * position
  assign rx_mem.wr_en   = rx_cw_wr_en && link_seq_ok;
  assign rx_mem.wr_be   = {`HRP_LANES{1'b1}};
  assign rx_mem.wr_addr = {rx_cw_seq, rx_cw_index};
  assign rx_mem.wr_data = rx_cw_data;
  assign rx_mem.rd_addr = {ctrl_index[`HRP_IDX_RX_SEQ], ctrl_index[`HRP_IDX_RX_X]};

  // Transmit writes need the layer-1 enable and a real section
  assign tx_mem.wr_en   = wr_req && hit_tx && tx_seq_ok &&
                          layer1_configuration_reg[`HRP_L1_TX_CW_EN];
  assign tx_mem.wr_be   = host_byteenable;
  assign tx_mem.wr_addr = {ctrl_index[`HRP_IDX_TX_SEQ], ctrl_index[`HRP_IDX_TX_X]};
  assign tx_mem.wr_data = host_writedata;
  assign tx_mem.rd_addr = {tx_cw_seq, tx_cw_index};
  assign tx_cw_data     = tx_mem.rd_data;

  hrp_cw_mem u_rx_table (
    .ref_clk (ref_clk),
    .port    (rx_mem.mem)
  );

  hrp_cw_mem u_tx_table (
    .ref_clk (ref_clk),
    .port    (tx_mem.mem)
  );

  // ----------------------------------------------------------------------
  // Read path
  // ----------------------------------------------------------------------
  // Plain registers; transmit table and unused words read zero
  always_comb begin
    read_mux = `HRP_ZERO;
    if (hit_status) begin
      read_mux = int_status;
    end else if (hit_enable) begin
      read_mux = int_enable;
    end else if (hit_l1) begin
      read_mux = layer1_configuration_reg;
    end else if (hit_index) begin
      read_mux = ctrl_index;
    end else if (reg_index == `HRP_OFS_CORE_STATUS) begin
      read_mux = core_status;
    end
  end

  // Receive table costs one extra cycle: RAM output is registered
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      rd_state      <= HRP_RD_IDLE;
      host_readdata <= `HRP_ZERO;
    end else begin
      case (rd_state)
        HRP_RD_IDLE: begin
          if (host_read && hit_rx) begin
            rd_state <= HRP_RD_MEM;
          end else if (host_read) begin
            host_readdata <= read_mux;
            rd_state      <= HRP_RD_DONE;
          end
        end
        HRP_RD_MEM: begin
          host_readdata <= rx_seq_ok ? rx_mem.rd_data : `HRP_ZERO;
          rd_state      <= HRP_RD_DONE;
        end
        HRP_RD_DONE: begin
          rd_state <= HRP_RD_IDLE;
        end
        default: begin
          rd_state <= HRP_RD_IDLE;
        end
      endcase
    end
  end

  // Writes never stall; reads hold wait until data is registered
  assign host_waitrequest = host_read && (rd_state != HRP_RD_DONE);

endmodule // hrp_top

// ==== tb/hrp_host_model.sv ====
`timescale 1ns/1ps
module hrp_host_model
  import hrp_pkg::*;
(
  input  wire logic        ref_clk,
  input  wire logic [31:0] host_readdata,
  input  wire logic        host_waitrequest,
  output logic      [15:0] host_address,
  output logic      [3:0]  host_byteenable,
  output logic             host_read,
  output logic             host_write,
  output logic      [31:0] host_writedata
);
  // ----------------------------------------
  // Bus master, one word per transfer
  // ----------------------------------------
  // Idle bus at time zero
  initial begin
    host_address    = 16'h0000;
    host_byteenable = 4'h0;
    host_read       = 1'b0;
    host_write      = 1'b0;
    host_writedata  = 32'h0000_0000;
  end

  // Held until waitrequest is seen low; bounded so a stall shows as x
  task automatic xfer(input logic rd, input logic [15:0] a, input hrp_word_t d,
                      input logic [3:0] be, output hrp_word_t q);
    @(negedge ref_clk);
    host_address    = a;
    host_byteenable = be;
    host_writedata  = d;
    host_read       = rd;
    host_write      = !rd;
    q = 'x;
    for (int n = 0; n < 8; n++) begin
      #1;
      if (host_waitrequest === 1'b0) begin
        q = host_readdata;
        break;
      end
      @(negedge ref_clk);
    end
    @(negedge ref_clk);
    host_read      = 1'b0;
    host_write     = 1'b0;
    host_writedata = ~d; // Released data and address lines never keep the old value
    host_address   = ~a;
  endtask
endmodule // hrp_host_model

// ==== tb/hrp_top_bench.sv ====
`timescale 1ns/1ps
`include "hrp_regs.svh"
module hrp_top_bench
  import hrp_pkg::*;
  ;
  // ----------------------------------------
  // Stimulus nets
  // ----------------------------------------
  logic        ref_clk = 1'b0;
  logic        reset_n = 1'b0;
  logic [7:0]  core_event = 8'h00;
  hrp_word_t   core_status = 32'h0000_0000;
  logic        rx_cw_wr_en = 1'b0;
  logic [7:0]  rx_cw_index = 8'h00;
  logic [3:0]  rx_cw_seq = 4'h0;
  hrp_word_t   rx_cw_data = 32'h0000_0000;
  logic [7:0]  tx_cw_index = 8'h00;
  logic [3:0]  tx_cw_seq = 4'h0;
  wire  [15:0] host_address;
  wire  [3:0]  host_byteenable;
  wire         host_read, host_write, host_waitrequest, host_irq;
  wire  [31:0] host_writedata, host_readdata, layer1_config, tx_cw_data;
  int          fail_count = 0;
  int          samples_checked = 0;

  // 250 MHz
  initial forever #2 ref_clk = ~ref_clk;

  hrp_top dut (.ref_clk, .reset_n, .host_address, .host_byteenable, .host_read, .host_write,
    .host_writedata, .host_readdata, .host_waitrequest, .host_irq, .core_event, .core_status,
    .layer1_config, .rx_cw_wr_en, .rx_cw_index, .rx_cw_seq, .rx_cw_data, .tx_cw_index,
    .tx_cw_seq, .tx_cw_data);
  hrp_host_model host (.ref_clk, .host_readdata, .host_waitrequest, .host_address,
    .host_byteenable, .host_read, .host_write, .host_writedata);

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  task automatic chk(input hrp_word_t got, input hrp_word_t exp);
    samples_checked++;
    if (got !== exp) begin
      fail_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [15:0] a, input hrp_word_t d, input logic [3:0] be);
    hrp_word_t q;
    host.xfer(1'b0, a, d, be, q);
  endtask

  task automatic rd(input logic [15:0] a, output hrp_word_t q);
    host.xfer(1'b1, a, $urandom, 4'hf, q);
  endtask

  task automatic pulse(input logic [7:0] e);
    @(negedge ref_clk);
    core_event = e;
    @(negedge ref_clk);
    core_event = 8'h00;
  endtask

  // Transmit table is registered: address one cycle, data the next
  task automatic tx_peek(input logic [7:0] x, input logic [3:0] s, output hrp_word_t q);
    @(negedge ref_clk);
    tx_cw_index = x;
    tx_cw_seq = s;
    @(negedge ref_clk);
    q = tx_cw_data;
  endtask

  function automatic hrp_word_t merge(hrp_word_t o, hrp_word_t n, logic [3:0] be);
    for (int i = 0; i < 4; i++)
      if (be[i]) o[8*i +: 8] = n[8*i +: 8];
    return o;
  endfunction

  task automatic wrap_up;
    $display("checks=%0d mismatches=%0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  // Watchdog, far beyond the few hundred cycles needed
  initial begin
    #100000;
    fail_count++;
    wrap_up;
  end

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  initial begin
    hrp_word_t  v, d, e;
    logic [3:0] b, s;
    logic [7:0] x;
    d = $urandom(27);
    repeat (20) @(negedge ref_clk);
    reset_n = 1'b1;
    repeat (3) @(negedge ref_clk);
    core_status = $urandom;
    // Receive table has no reset value: give entry zero a known word first
    e = $urandom;
    {rx_cw_wr_en, rx_cw_data} = {1'b1, e};
    @(negedge ref_clk);
    rx_cw_wr_en = 1'b0;
    wr(16'h0007, $urandom, 4'hf);
    for (int i = 0; i < 9; i++) begin
      rd((i == 8) ? 16'h8000 | 16'($urandom) : 16'(i), v);
      chk(v, (i == 6) ? core_status : (i == 4) ? e : `HRP_ZERO);
    end
    e = `HRP_RST_INT_ENABLE;
    repeat (6) begin
      d = $urandom;
      b = 4'($urandom);
      wr(`HRP_OFS_INT_ENABLE, d, b);
      e = merge(e, d, b);
      rd(`HRP_OFS_INT_ENABLE, v);
      chk(v, e);
    end
    wr(`HRP_OFS_INT_ENABLE, 32'h0000_0001, 4'hf);
    pulse(8'h02);
    chk({31'h0, host_irq}, 32'h0);
    rd(`HRP_OFS_INT_STATUS, v);
    chk(v, 32'h0000_0002);
    pulse(8'h01);
    chk({31'h0, host_irq}, 32'h1);
    wr(`HRP_OFS_INT_STATUS, 32'h0000_0003, 4'h1);
    chk({31'h0, host_irq}, 32'h0);
    // Receive words; first one is subchannel 1, position 1
    for (int k = 0; k < 4; k++) begin
      x = (k == 0) ? 8'd65 : 8'($urandom % 64 + 64 * (k - 1));
      s = 4'($urandom % 12);
      d = $urandom;
      @(negedge ref_clk);
      {rx_cw_wr_en, rx_cw_index, rx_cw_seq, rx_cw_data} = {1'b1, x, s, d};
      @(negedge ref_clk);
      rx_cw_wr_en = 1'b0;
      rx_cw_data = ~d;
      wr(`HRP_OFS_CTRL_INDEX, {20'h0, s, x}, 4'hf);
      rd(`HRP_OFS_RX_CTRL, v);
      chk(v, d);
    end
    wr(`HRP_OFS_CTRL_INDEX, {20'h0, `HRP_CW_SECTIONS, x}, 4'hf);
    rd(`HRP_OFS_RX_CTRL, v);
    chk(v, `HRP_ZERO);
    wr(`HRP_OFS_L1_CFG, 32'h0000_0001, 4'hf);
    chk(layer1_config, 32'h0000_0001);
    repeat (3) begin
      x = 8'($urandom);
      s = 4'($urandom % 12);
      d = $urandom;
      wr(`HRP_OFS_CTRL_INDEX, {4'h0, s, x, 16'h0}, 4'hf);
      wr(`HRP_OFS_TX_CTRL, d, 4'hf);
      tx_peek(x, s, v);
      chk(v, d);
    end
    // Transmit write refused once the layer-1 enable is off
    wr(`HRP_OFS_L1_CFG, `HRP_ZERO, 4'hf);
    wr(`HRP_OFS_TX_CTRL, ~d, 4'hf);
    tx_peek(x, s, v);
    chk(v, d);
    wr(`HRP_OFS_L1_CFG, 32'h0000_0001, 4'hf);
    wr(`HRP_OFS_INT_ENABLE, 32'hffff_ffff, 4'hf);
    @(negedge ref_clk);
    reset_n = 1'b0;
    repeat (2) @(negedge ref_clk);
    reset_n = 1'b1;
    chk(layer1_config, `HRP_RST_L1_CFG);
    repeat (3) @(negedge ref_clk);
    rd(`HRP_OFS_INT_ENABLE, v);
    chk(v, `HRP_RST_INT_ENABLE);
    wrap_up;
  end
endmodule // hrp_top_bench

// ==== tb/hrp_top_monitor.sv ====
`timescale 1ns/1ps
`include "hrp_regs.svh"
module hrp_top_monitor
  import hrp_pkg::*;
#(
  parameter bit BYTE_ADDRESSING = 1'b0,
  parameter bit CW_ACCESS_EN    = 1'b1
) (
  input wire logic                   ref_clk,
  input wire logic                   reset_n,
  input wire logic [15:0]            host_address,
  input wire logic [`HRP_LANES-1:0]  host_byteenable,
  input wire logic                   host_read,
  input wire logic                   host_write,
  input wire logic [31:0]            host_writedata,
  input wire logic [31:0]            host_readdata,
  input wire logic                   host_waitrequest,
  input wire logic                   host_irq,
  input wire logic [`HRP_EVENTS-1:0] core_event,
  input wire logic [31:0]            layer1_config
);
  // ----------------------------------------
  // Helper logic
  // ----------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!reset_n);
  wire logic [15:0] wa = BYTE_ADDRESSING ? host_address >> `HRP_BYTE_SHIFT : host_address;
  // Receive table read only exists with the control-word option
  wire logic        rx_hit = CW_ACCESS_EN && (wa == `HRP_OFS_RX_CTRL);
  wire logic        wr = host_write && !host_read;
  logic [7:0]       en;

  // Shadow of the low enable byte; upper status bits have no source
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n)
      en <= 8'h00;
    else if (wr && wa == `HRP_OFS_INT_ENABLE && host_byteenable[0])
      en <= host_writedata[7:0];
  end

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  AST_WRITE_NO_WAIT: assert property (wr |-> !host_waitrequest)
    else $error("write stalled");
  AST_WAIT_ONLY_READ: assert property (!host_read |-> !host_waitrequest)
    else $error("wait without read");
  AST_READ_ONE: assert property ($rose(host_read) && !rx_hit
    |-> host_waitrequest ##1 !host_waitrequest) else $error("read latency wrong");
  AST_READ_RX: assert property ($rose(host_read) && rx_hit
    |-> host_waitrequest [*2] ##1 !host_waitrequest) else $error("rx read latency wrong");
  AST_DATA_STANDS: assert property (!$past(host_read) |-> $stable(host_readdata))
    else $error("read data moved");
  AST_UNUSED_ZERO: assert property ($rose(host_read) && (wa > `HRP_OFS_CORE_STATUS
    || wa == `HRP_OFS_TX_CTRL) |=> host_readdata == `HRP_ZERO) else $error("unused read");
  AST_L1_WRITE: assert property (wr && wa == `HRP_OFS_L1_CFG && host_byteenable == 4'hf
    |=> layer1_config == $past(host_writedata)) else $error("layer1 not written");
  AST_IRQ_SET: assert property (|(core_event & en) && !host_write |=> host_irq)
    else $error("irq missing");
  AST_IRQ_MASK: assert property (en == 8'h00 |-> !host_irq)
    else $error("irq while masked");
endmodule // hrp_top_monitor

bind hrp_top hrp_top_monitor #(.BYTE_ADDRESSING(BYTE_ADDRESSING), .CW_ACCESS_EN(CW_ACCESS_EN))
  u_mon (.ref_clk, .reset_n, .host_address, .host_byteenable, .host_read, .host_write,
         .host_writedata, .host_readdata, .host_waitrequest, .host_irq, .core_event,
         .layer1_config);
